// File: dv/otp_burn_ecc_chk.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the burn sequencer
module otp_burn_ecc_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start,
  input wire logic power_cycled,
  input wire logic power_cycle_req,
  input wire otp_burn_pkg::result_t result,
  input wire otp_burn_pkg::fail_t fail_code,
  input wire logic device_fault,
  input wire logic sclk_a,
  input wire logic cs_a_n,
  input wire logic sclk_b,
  input wire logic cs_b_n
);
  import otp_burn_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_reset_vals: assert property ($rose(reset_n) |-> result == RES_IDLE &&
    fail_code == FAIL_NONE && cs_a_n && cs_b_n && !power_cycle_req)
    else $error("outputs not at reset values");
  chk_start_take: assert property (result == RES_IDLE && start |=>
    result == RES_BUSY && power_cycle_req) else $error("start not taken");
  chk_pwr_hold: assert property (power_cycle_req && !power_cycled |=>
    power_cycle_req) else $error("power request dropped early");
  chk_pwr_drop: assert property (power_cycled [*3] |-> ##[1:4]
    !power_cycle_req) else $error("power request stuck");
  chk_pass_clean: assert property (result == RES_PASS |->
    fail_code == FAIL_NONE) else $error("pass with failure code");
  chk_fail_coded: assert property (result == RES_FAIL |->
    fail_code != FAIL_NONE) else $error("failure without code");
  chk_fail_quiet: assert property (result == RES_FAIL |->
    cs_a_n && cs_b_n) else $error("frames after failure");
  chk_fault_sticky: assert property (device_fault |=> device_fault)
    else $error("fault flag cleared");
  chk_one_die: assert property (!cs_a_n |-> cs_b_n && !sclk_b)
    else $error("both dies addressed");
  chk_sclk_half: assert property ($rose(sclk_a) |-> sclk_a [*4]
    ##1 !sclk_a) else $error("serial clock high phase wrong");
  chk_cs_gap: assert property ($rose(cs_a_n) |=> cs_a_n [*3])
    else $error("select gap too short");
  chk_idle_clk: assert property (cs_a_n |-> !sclk_a)
    else $error("serial clock moves while deselected");
endmodule // otp_burn_ecc_chk

bind otp_burn_ecc_sequencer otp_burn_ecc_chk chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .start(start),
  .power_cycled(power_cycled), .power_cycle_req(power_cycle_req),
  .result(result), .fail_code(fail_code), .device_fault(device_fault),
  .sclk_a(sclk_a), .cs_a_n(cs_a_n), .sclk_b(sclk_b), .cs_b_n(cs_b_n)
);

// File: dv/otp_burn_ecc_sequencer_test.sv
`timescale 1ns/10ps
// ==========================================================
// Whole burn runs on both dies against two sensor models
module otp_burn_ecc_sequencer_test;
  import otp_burn_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic power_cycled = 1'b0;
  logic die_sel = 1'b0;
  logic inj = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] cfg_a = 8'h3C;
  logic [7:0] cfg_b = 8'h05;
  logic [7:0] cfg_c = 8'h81;
  logic power_cycle_req, device_fault;
  logic sclk_a, cs_a_n, mosi_a, miso_a, sclk_b, cs_b_n, mosi_b, miso_b;
  logic [7:0] burns_a, burns_b;
  result_t result;
  fail_t fail_code;
  int error_cnt = 0;
  int checks = 0;

  always #50 clk_sys = ~clk_sys;

  otp_burn_ecc_sequencer uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .start(start), .power_cycled(power_cycled), .die_sel(die_sel),
    .cfg_a(cfg_a), .cfg_b(cfg_b), .cfg_c(cfg_c),
    .power_cycle_req(power_cycle_req), .result(result),
    .fail_code(fail_code), .device_fault(device_fault),
    .sclk_a(sclk_a), .cs_a_n(cs_a_n), .mosi_a(mosi_a), .miso_a(miso_a),
    .sclk_b(sclk_b), .cs_b_n(cs_b_n), .mosi_b(mosi_b), .miso_b(miso_b));
  sensor_dev_model dev_a (.sclk(sclk_a), .cs_n(cs_a_n), .mosi(mosi_a),
    .pwr_cycle(power_cycled & ~die_sel), .inject_err(inj), .mode(mode),
    .miso(miso_a), .burn_cnt(burns_a));
  sensor_dev_model dev_b (.sclk(sclk_b), .cs_n(cs_b_n), .mosi(mosi_b),
    .pwr_cycle(power_cycled & die_sel), .inject_err(1'b0), .mode(mode),
    .miso(miso_b), .burn_cnt(burns_b));

  task automatic cmp(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (exp !== got) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic final_report;
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A second start mid-run must be ignored by the busy sequencer
  task automatic run(input logic die, input logic [1:0] m, input result_t er,
                     input fail_t ef, input logic [7:0] eb);
    logic [7:0] a0, b0;
    int n;
    a0 = burns_a;
    b0 = burns_b;
    n = 0;
    die_sel <= die;
    mode <= m;
    start <= 1'b1;
    do begin
      @(posedge clk_sys);
      start <= (n == 600);
      power_cycled <= power_cycle_req;
      n++;
    end while (n < 20000 && !(n > 4 && result inside {RES_PASS, RES_FAIL}));
    if (n >= 20000) begin
      $display("BAD run_done expected 1 seen 0");
      error_cnt++;
      final_report();
    end
    cmp("result", 8'(er), 8'(result));
    cmp("fail_code", 8'(ef), 8'(fail_code));
    cmp("burns_a", a0 + (die ? 8'h00 : eb), burns_a);
    cmp("burns_b", b0 + (die ? eb : 8'h00), burns_b);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    inj <= 1'b1;
    run(1'b0, 2'h0, RES_PASS, FAIL_NONE, 8'h01);
    cmp("device_fault", 8'h01, {7'h00, device_fault});
    cmp("fuse_cfg_a", cfg_a, dev_a.fuse[24][7:0]);
    cmp("fuse_cfg_c", cfg_c, dev_a.fuse[26][7:0]);
    cmp("fuse_zero_low", 8'h1C, dev_a.fuse[22][7:0]);
    cmp("fuse_zero_high", 8'hA9, dev_a.fuse[23][7:0]);
    cmp("fuse_key", 8'h8D, dev_a.fuse[27][7:0]);
    run(1'b0, 2'h1, RES_FAIL, FAIL_PRE_BURN, 8'h00);
    run(1'b0, 2'h2, RES_FAIL, FAIL_GUARD_BAND, 8'h01);
    run(1'b0, 2'h3, RES_FAIL, FAIL_POWER_ON, 8'h01);
    run(1'b1, 2'h0, RES_PASS, FAIL_NONE, 8'h01);
    final_report();
  end
endmodule // otp_burn_ecc_sequencer_test

// File: dv/sensor_dev_model.sv
`timescale 1ns/10ps
// ==========================================================
// Sensor model: shadow and fuse images behind serial frames
// Mode 1 sticks bit 4 on writes to 0x19, 2 weakens a fuse under margin,
// 3 corrupts the power-on reload; 0 is a healthy part
module sensor_dev_model #(
  parameter logic [13:0] ANGLE = 14'h2A5C
) (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic pwr_cycle,
  input wire logic inject_err,
  input wire logic [1:0] mode,
  output logic miso,
  output logic [7:0] burn_cnt
);
  logic [15:0] shadow [21:27];
  logic [15:0] fuse [21:27];
  logic [15:0] cmd, din, dout;
  logic [1:0] flags;
  logic access, margin, err_pend;
  int n, polls;

  function automatic logic [15:0] rd(input logic [13:0] a);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 21; i <= 26; i++) x ^= shadow[i][7:0];
    case (a)
      14'h3FFF: rd = {2'h0, ANGLE};
      14'h3FD0: rd = {9'h000, x[6:0]};
      14'h0003: rd = (polls > 0) ? 16'h0008 : 16'h0001;
      14'h0001: rd = {12'h000, flags, 2'h0};
      default: rd = (a >= 14'h0015 && a <= 14'h001B) ? shadow[a] : 16'h0000;
    endcase
  endfunction

  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    if (a >= 14'h0015 && a <= 14'h001B) begin
      shadow[a] = (mode == 2'h1 && a == 14'h0019) ? d | 16'h0010 : d;
    end
    if (a == 14'h0003) begin
      access = access | d[0];
      margin = margin | d[6];
      if (d[3] && access) begin
        for (int i = 21; i <= 27; i++) fuse[i] = shadow[i];
        burn_cnt++;
        polls = 2;
      end
      // Weak fuse only shows under the guard margin
      if (d[2]) begin
        for (int i = 21; i <= 27; i++) shadow[i] = fuse[i] ^
          {15'h0000, margin && mode == 2'h2 && i == 24};
      end
    end
  endtask

  initial begin
    burn_cnt = 8'h00;
    flags = 2'h0;
    err_pend = 1'b0;
    miso = 1'b0;
    n = 0;
    for (int i = 21; i <= 27; i++) fuse[i] = 16'h0000;
  end

  always @(posedge pwr_cycle) begin
    access = 1'b0;
    margin = 1'b0;
    polls = 0;
    for (int i = 21; i <= 27; i++) shadow[i] = fuse[i] ^
      {14'h0000, mode == 2'h3 && burn_cnt != 8'h00 && i == 27, 1'b0};
  end

  // Single-bit fault is corrected in the data, only flagged
  always @(posedge inject_err) begin
    err_pend = 1'b1;
    flags = flags | 2'h1;
  end

  always @(negedge cs_n) n = 0;

  always @(posedge cs_n) begin
    miso = ~miso;
    if (n == 32 && !cmd[14]) wr(cmd[13:0], din);
  end

  always @(negedge sclk) if (!cs_n) begin
    if (n < 16) cmd = {cmd[14:0], mosi};
    else din = {din[14:0], mosi};
    n++;
    if (n == 16) begin
      dout = cmd[14] ? rd(cmd[13:0]) : 16'h0000;
      if (cmd[14] && cmd[13:0] == 14'h0003 && polls > 0) polls--;
      dout[14] = dout[14] | err_pend;
      err_pend = 1'b0;
    end
  end

  // Command phase shows a changing line, not a held bit
  always @(posedge sclk) if (!cs_n) begin
    miso = (n >= 16) ? dout[15] : ~miso;
    dout = dout << 1;
  end
endmodule // sensor_dev_model

// File: inc/otp_burn_pkg.sv
package otp_burn_pkg;
  typedef enum logic [1:0] {
    RES_IDLE,
    RES_BUSY,
    RES_PASS,
    RES_FAIL
  } result_t;
  typedef enum logic [1:0] {
    FAIL_NONE,
    FAIL_PRE_BURN,
    FAIL_GUARD_BAND,
    FAIL_POWER_ON
  } fail_t;
endpackage

// File: inc/otp_burn_regs.svh
`ifndef OTP_BURN_REGS_SVH
`define OTP_BURN_REGS_SVH

// Device register addresses (14-bit address space)
`define ADDR_CFG_FIRST 14'h0015
`define ADDR_CFG_LAST 14'h001B
`define ADDR_CFG_PRE_ECC_LAST 14'h001A
`define ADDR_POWER_CHECK_FIRST 14'h0016
`define ADDR_ZERO_LOW 14'h0016
`define ADDR_ZERO_HIGH 14'h0017
`define ADDR_APP_CFG_A 14'h0018
`define ADDR_APP_CFG_B 14'h0019
`define ADDR_APP_CFG_C 14'h001A
`define ADDR_ECC_CTRL 14'h001B
`define ADDR_FAULT_FLAGS 14'h0001
`define ADDR_PROG_CTRL 14'h0003
`define ADDR_ANGLE_COMP 14'h3FFF
`define ADDR_ECC_SOURCE 14'h3FD0
`define ADDR_SHADOW_FIRST 14'h0015
`define ADDR_SHADOW_LAST 14'h001B

// Field positions
`define ECC_EN_BIT 7
`define ZERO_LOW_MSB 5
`define ZERO_HIGH_LSB 6
`define PROG_ACCESS_BIT 0
`define PROG_BURN_BIT 3
`define PROG_MARGIN_BIT 6
`define PROG_RELOAD_BIT 2

// Values
`define PROG_DONE_VALUE 16'h0001
`define SHADOW_CLEAR_VALUE 8'h00

// Timing
`define SCLK_HALF_CYCLES 4
`define CS_GAP_CYCLES 4

`endif

// File: logic/otp_burn_ecc_sequencer.sv
`timescale 1ns/10ps
// ===========================================================
// Functional notes
// - Enable protection, fetch checksum, write, program
// - Checksum write keeps protection enable bit set
// - Sequence starts after power cycle, writes settings
// - Zero angle split into low/high registers
// - Read back settings before protection setup
// - Enable, read key, write key, enable again
// - Read and compare all settings before burn
// - Set fuse access enable after match only
// - Start burn after fuse access enabled
// - Poll programming control until value one
// - Clear shadow memory with zeros after burn
// - Guard margin only for burn verification
// - Reload trigger refreshes settings from fuses
// - Post-refresh compare; mismatch means no reprogram
// - After power cycle, compare again
// - Second die programmed separately via its pins
`include "otp_burn_regs.svh"

module otp_burn_ecc_sequencer (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start,
  input wire logic power_cycled,
  input wire logic die_sel,
  input wire logic [7:0] cfg_a,
  input wire logic [7:0] cfg_b,
  input wire logic [7:0] cfg_c,
  output logic power_cycle_req,
  output otp_burn_pkg::result_t result,
  output otp_burn_pkg::fail_t fail_code,
  output logic device_fault,
  output logic sclk_a,
  output logic cs_a_n,
  output logic mosi_a,
  input wire logic miso_a,
  output logic sclk_b,
  output logic cs_b_n,
  output logic mosi_b,
  input wire logic miso_b
);
  import otp_burn_pkg::*;

  // ===========================================================
  // Sequence states
  typedef enum logic [4:0] {
    S_IDLE, S_PWR1, S_WR_CFG, S_RD_ANGLE, S_WR_ZERO, S_RD_PRE,
    S_ECC_EN1, S_RD_KEY, S_WR_KEY, S_ECC_EN2, S_RD_CMP1, S_PROG_EN,
    S_BURN, S_POLL, S_CLEAR, S_MARGIN, S_RELOAD, S_RD_CMP2, S_PWR2,
    S_RD_CMP3, S_PASS, S_FAIL
  } seq_t;

  seq_t st_r;
  logic [2:0] idx_r;
  logic issued_r;
  logic [13:0] angle_r;
  logic [15:0] key_r;
  logic [7:0] exp_r [0:6];
  result_t result_r;
  fail_t fail_r;
  logic die_r;
  logic pwr_req_r;
  logic pc_s1_r, pc_s2_r;

  logic fm_start, fm_rd, fm_busy, fm_done, fm_fault;
  logic [13:0] fm_addr;
  logic [15:0] fm_wdata, fm_rdata;
  logic fm_sclk, fm_cs_n, fm_mosi;

  always_ff @(posedge clk_sys) begin
    pc_s1_r <= power_cycled;
    pc_s2_r <= pc_s1_r;
  end

  // ===========================================================
  // Access decode for each state
  wire [13:0] cfg_idx_addr = `ADDR_CFG_FIRST + 14'(idx_r);
  wire [7:0] cfg_val = (idx_r == 3'd0) ? cfg_a :
                       (idx_r == 3'd1) ? cfg_b : cfg_c;
  wire [7:0] zero_low = {2'b00, angle_r[`ZERO_LOW_MSB:0]};
  wire [7:0] zero_high = angle_r[13:`ZERO_HIGH_LSB];
  wire [7:0] ecc_en_val = 8'(1 << `ECC_EN_BIT);
  // Key written with enable kept high in the same word
  wire [7:0] key_val = key_r[7:0] | ecc_en_val;
  wire [7:0] rd_byte = fm_rdata[7:0];
  wire [2:0] cmp_idx = idx_r;
  wire cmp_ok = (rd_byte == exp_r[cmp_idx]);
  wire [2:0] last_cfg_idx = 3'(`ADDR_CFG_LAST - `ADDR_CFG_FIRST);
  wire [2:0] pre_last_idx = 3'(`ADDR_CFG_PRE_ECC_LAST - `ADDR_CFG_FIRST);
  wire [2:0] pwr_first_idx =
    3'(`ADDR_POWER_CHECK_FIRST - `ADDR_CFG_FIRST);

  always_comb begin
    fm_rd = 1'b1;
    fm_addr = `ADDR_CFG_FIRST;
    fm_wdata = 16'h0000;
    case (st_r)
      S_WR_CFG: begin
        fm_rd = 1'b0;
        fm_addr = `ADDR_APP_CFG_A + 14'(idx_r);
        fm_wdata = {8'h00, cfg_val};
      end
      S_RD_ANGLE: fm_addr = `ADDR_ANGLE_COMP;
      S_WR_ZERO: begin
        fm_rd = 1'b0;
        fm_addr = (idx_r == 3'd0) ? `ADDR_ZERO_LOW : `ADDR_ZERO_HIGH;
        fm_wdata = {8'h00, (idx_r == 3'd0) ? zero_low : zero_high};
      end
      S_RD_PRE, S_RD_CMP1, S_RD_CMP2, S_RD_CMP3: fm_addr = cfg_idx_addr;
      S_ECC_EN1, S_ECC_EN2: begin
        fm_rd = 1'b0;
        fm_addr = `ADDR_ECC_CTRL;
        fm_wdata = {8'h00, (st_r == S_ECC_EN1) ? ecc_en_val : key_val};
      end
      S_RD_KEY: fm_addr = `ADDR_ECC_SOURCE;
      S_WR_KEY: begin
        fm_rd = 1'b0;
        fm_addr = `ADDR_ECC_CTRL;
        fm_wdata = {8'h00, key_val};
      end
      S_PROG_EN: begin
        fm_rd = 1'b0;
        fm_addr = `ADDR_PROG_CTRL;
        fm_wdata = 16'(1 << `PROG_ACCESS_BIT);
      end
      S_BURN: begin
        fm_rd = 1'b0;
        fm_addr = `ADDR_PROG_CTRL;
        fm_wdata = 16'(1 << `PROG_BURN_BIT);
      end
      S_POLL: fm_addr = `ADDR_PROG_CTRL;
      S_CLEAR: begin
        fm_rd = 1'b0;
        fm_addr = cfg_idx_addr;
        fm_wdata = {8'h00, `SHADOW_CLEAR_VALUE};
      end
      S_MARGIN: begin
        fm_rd = 1'b0;
        fm_addr = `ADDR_PROG_CTRL;
        fm_wdata = 16'(1 << `PROG_MARGIN_BIT);
      end
      S_RELOAD: begin
        fm_rd = 1'b0;
        fm_addr = `ADDR_PROG_CTRL;
        fm_wdata = 16'(1 << `PROG_RELOAD_BIT);
      end
      default: begin
        fm_rd = 1'b1;
      end
    endcase
  end

  wire access_state = !(st_r == S_IDLE || st_r == S_PWR1 ||
                        st_r == S_PWR2 || st_r == S_PASS ||
                        st_r == S_FAIL);
  assign fm_start = access_state && !issued_r && !fm_busy;

  // ===========================================================
  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_r <= S_IDLE;
      idx_r <= 3'd0;
      issued_r <= 1'b0;
      angle_r <= 14'h0000;
      key_r <= 16'h0000;
      result_r <= RES_IDLE;
      fail_r <= FAIL_NONE;
      die_r <= 1'b0;
      pwr_req_r <= 1'b0;
      for (int i = 0; i < 7; i++) begin
        exp_r[i] <= 8'h00;
      end
    end else begin
      if (fm_start) begin
        issued_r <= 1'b1;
      end
      if (fm_done) begin
        issued_r <= 1'b0;
      end
      case (st_r)
        S_IDLE: begin
          if (start) begin
            die_r <= die_sel;
            result_r <= RES_BUSY;
            fail_r <= FAIL_NONE;
            pwr_req_r <= 1'b1;
            st_r <= S_PWR1;
          end
        end
        S_PWR1: begin
          if (pc_s2_r) begin
            pwr_req_r <= 1'b0;
            idx_r <= 3'd0;
            st_r <= S_WR_CFG;
          end
        end
        S_WR_CFG: if (fm_done) begin
          exp_r[3'(idx_r + 3'd3)] <= cfg_val;
          idx_r <= idx_r + 3'd1;
          if (idx_r == 3'd2) begin
            idx_r <= 3'd0;
            st_r <= S_RD_ANGLE;
          end
        end
        S_RD_ANGLE: if (fm_done) begin
          angle_r <= fm_rdata[13:0];
          st_r <= S_WR_ZERO;
        end
        S_WR_ZERO: if (fm_done) begin
          exp_r[3'(idx_r + 3'd1)] <= fm_wdata[7:0];
          idx_r <= idx_r + 3'd1;
          if (idx_r == 3'd1) begin
            idx_r <= 3'd0;
            st_r <= S_RD_PRE;
          end
        end
        S_RD_PRE: if (fm_done) begin
          if (idx_r == 3'd0) begin
            exp_r[0] <= rd_byte;
          end
          idx_r <= idx_r + 3'd1;
          if (idx_r == pre_last_idx) begin
            st_r <= S_ECC_EN1;
          end
        end
        S_ECC_EN1: if (fm_done) st_r <= S_RD_KEY;
        S_RD_KEY: if (fm_done) begin
          key_r <= fm_rdata;
          st_r <= S_WR_KEY;
        end
        S_WR_KEY: if (fm_done) begin
          exp_r[6] <= key_val;
          st_r <= S_ECC_EN2;
        end
        S_ECC_EN2: if (fm_done) begin
          idx_r <= 3'd0;
          st_r <= S_RD_CMP1;
        end
        S_RD_CMP1: if (fm_done) begin
          idx_r <= idx_r + 3'd1;
          if (!cmp_ok) begin
            fail_r <= FAIL_PRE_BURN;
            st_r <= S_FAIL;
          end else if (idx_r == last_cfg_idx) begin
            st_r <= S_PROG_EN;
          end
        end
        S_PROG_EN: if (fm_done) st_r <= S_BURN;
        S_BURN: if (fm_done) st_r <= S_POLL;
        S_POLL: if (fm_done && fm_rdata == `PROG_DONE_VALUE) begin
          idx_r <= 3'd0;
          st_r <= S_CLEAR;
        end
        S_CLEAR: if (fm_done) begin
          idx_r <= idx_r + 3'd1;
          if (idx_r == last_cfg_idx) begin
            st_r <= S_MARGIN;
          end
        end
        S_MARGIN: if (fm_done) st_r <= S_RELOAD;
        S_RELOAD: if (fm_done) begin
          idx_r <= 3'd0;
          st_r <= S_RD_CMP2;
        end
        S_RD_CMP2: if (fm_done) begin
          idx_r <= idx_r + 3'd1;
          if (!cmp_ok) begin
            fail_r <= FAIL_GUARD_BAND;
            st_r <= S_FAIL;
          end else if (idx_r == last_cfg_idx) begin
            pwr_req_r <= 1'b1;
            st_r <= S_PWR2;
          end
        end
        S_PWR2: if (pc_s2_r) begin
          pwr_req_r <= 1'b0;
          idx_r <= pwr_first_idx;
          st_r <= S_RD_CMP3;
        end
        S_RD_CMP3: if (fm_done) begin
          idx_r <= idx_r + 3'd1;
          if (!cmp_ok) begin
            fail_r <= FAIL_POWER_ON;
            st_r <= S_FAIL;
          end else if (idx_r == last_cfg_idx) begin
            st_r <= S_PASS;
          end
        end
        S_PASS: begin
          result_r <= RES_PASS;
          st_r <= S_IDLE;
        end
        S_FAIL: begin
          result_r <= RES_FAIL;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ===========================================================
  // Serial engine, steered to the selected die
  wire miso_sel = die_r ? miso_b : miso_a;

  serial_frame_master u_frame (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(fm_start),
    .rd(fm_rd),
    .addr(fm_addr),
    .wdata(fm_wdata),
    .busy(fm_busy),
    .done(fm_done),
    .rdata(fm_rdata),
    .fault_seen(fm_fault),
    .sclk(fm_sclk),
    .cs_n(fm_cs_n),
    .mosi(fm_mosi),
    .miso(miso_sel)
  );

  // Unselected die sees an idle bus
  assign sclk_a = die_r ? 1'b0 : fm_sclk;
  assign cs_a_n = die_r ? 1'b1 : fm_cs_n;
  assign mosi_a = die_r ? 1'b0 : fm_mosi;
  assign sclk_b = die_r ? fm_sclk : 1'b0;
  assign cs_b_n = die_r ? fm_cs_n : 1'b1;
  assign mosi_b = die_r ? fm_mosi : 1'b0;
  assign power_cycle_req = pwr_req_r;
  assign result = result_r;
  assign fail_code = fail_r;
  assign device_fault = fm_fault;
endmodule // otp_burn_ecc_sequencer

// File: logic/serial_frame_master.sv
`timescale 1ns/10ps
// One 16-bit command plus one 16-bit data frame per access, mode 1.
// The device clock is made here by a divider of the system clock.
`include "otp_burn_regs.svh"

module serial_frame_master (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start,
  input wire logic rd,
  input wire logic [13:0] addr,
  input wire logic [15:0] wdata,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic fault_seen,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  typedef enum logic [1:0] {F_IDLE, F_SHIFT, F_GAP} fstate_t;
  fstate_t st_r;
  logic [5:0] bit_r;
  logic [3:0] div_r;
  logic [31:0] sh_r;
  logic [15:0] rx_r;
  logic miso_s1_r, miso_s2_r;
  logic sclk_r, done_r, fault_r;
  logic [15:0] rdata_r;

  wire half_tick = (div_r == 4'(`SCLK_HALF_CYCLES - 1));
  wire gap_end = (div_r == 4'(`CS_GAP_CYCLES - 1));
  wire [15:0] cmd_word = {~^{rd, addr}, rd, addr};

  always_ff @(posedge clk_sys) begin
    miso_s1_r <= miso;
    miso_s2_r <= miso_s1_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_r <= F_IDLE;
      bit_r <= 6'h00;
      div_r <= 4'h0;
      sh_r <= 32'h0000_0000;
      rx_r <= 16'h0000;
      sclk_r <= 1'b0;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        F_IDLE: begin
          div_r <= 4'h0;
          if (start) begin
            sh_r <= {cmd_word, rd ? 16'h0000 : wdata};
            bit_r <= 6'h00;
            st_r <= F_SHIFT;
          end
        end
        F_SHIFT: begin
          div_r <= half_tick ? 4'h0 : div_r + 4'h1;
          if (half_tick && bit_r == 6'h20) begin
            // A low half period after the last fall keeps select from
            // rising on the same edge at which the device takes a bit
            st_r <= F_GAP;
          end else if (half_tick) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              // Falling edge: the device has shifted, we sample
              rx_r <= {rx_r[14:0], miso_s2_r};
              bit_r <= bit_r + 6'h01;
            end else if (bit_r != 6'h00) begin
              // Rising edge: next bit out, so it is stable at the fall
              sh_r <= {sh_r[30:0], 1'b0};
            end
          end
        end
        F_GAP: begin
          div_r <= gap_end ? 4'h0 : div_r + 4'h1;
          if (gap_end) begin
            rdata_r <= rx_r;
            done_r <= 1'b1;
            st_r <= F_IDLE;
          end
          // Error flag rides in bit 14 of the response word
          if (gap_end && rx_r[14]) begin
            fault_r <= 1'b1;
          end
        end
        default: st_r <= F_IDLE;
      endcase
    end
  end

  assign busy = (st_r != F_IDLE);
  assign done = done_r;
  assign rdata = rdata_r;
  assign fault_seen = fault_r;
  assign sclk = sclk_r;
  assign cs_n = (st_r != F_SHIFT);
  assign mosi = sh_r[31];
endmodule // serial_frame_master
